// ==== crms_pkg.sv ====
// shared constants and carrier types for the core register model
package crms_pkg;
  localparam int          WREG_COUNT      = 16;
  localparam int          WREG_W          = 16;
  localparam int          ACC_W           = 40;
  localparam int          INSN_W          = 24;
  localparam int          PC_W            = 23;
  localparam int          PAGE_W          = 8;
  localparam logic [3:0]  SP_INDEX        = 4'hF;
  localparam logic [3:0]  FP_INDEX        = 4'hE;
  localparam logic [3:0]  DEFAULT_INDEX   = 4'h0;
  localparam logic [15:0] SP_RESET        = 16'h0800;
  localparam logic [7:0]  PAGE_RESET      = 8'h00;
  localparam logic [15:0] STATUS_RESET    = 16'h0000;
  localparam logic [2:0]  IRQ_PRIO_MIN    = 3'h1;
  localparam logic [2:0]  IRQ_PRIO_MAX    = 3'h7;
  localparam logic [3:0]  TRAP_PRIO_MIN   = 4'h8;
  localparam logic [3:0]  TRAP_PRIO_MAX   = 4'hF;
  localparam int          WINDOW_EXTRA_CYC = 1;
  // status word field positions
  localparam int BIT_CARRY   = 0;
  localparam int BIT_ZERO    = 1;
  localparam int BIT_OVF     = 2;
  localparam int BIT_NEG     = 3;
  localparam int BIT_RPT     = 4;
  localparam int BIT_PRIO_LO = 5;
  localparam int BIT_DCARRY  = 8;
  localparam int BIT_LOOP    = 9;
  localparam int BIT_SAB     = 10;
  localparam int BIT_OAB     = 11;
  localparam int BIT_SB      = 12;
  localparam int BIT_SA      = 13;
  localparam int BIT_OB      = 14;
  localparam int BIT_OA      = 15;
  // hardware-owned bits: software writes never touch these
  localparam logic [15:0] SW_RO_MASK   = 16'hC814;
  // read-and-clear bits
  localparam logic [15:0] SW_CLR_MASK  = 16'h3600;
  // bits carried by the shadow push/pop
  localparam logic [15:0] SHADOW_MASK  = 16'h010F;

  typedef struct packed {
    logic        carry;
    logic        zero;
    logic        zero_chain;
    logic        ovf;
    logic        neg;
    logic        dcarry;
  } crms_alu_flags_t;

  typedef struct packed {
    logic        wr;
    logic        byte_op;
    logic        high_byte;
    logic [3:0]  index;
    logic [15:0] data;
  } crms_wr_t;

  typedef struct packed {
    logic [15:0] start;
    logic [15:0] finish;
    logic [15:0] count;
  } crms_loop_t;
endpackage

// ==== crms_shadow.sv ====
// one shadow holding register with a push capture event; pops read SAVED in the host
`timescale 1ns/1ps
module crms_shadow import crms_pkg::*; #(
  parameter int W = 16
) (
  input  wire logic         CORE_CLK,
  input  wire logic         SYS_RST,
  input  wire logic         CLK_EN,
  input  wire logic         PUSH,
  input  wire logic [W-1:0] HOST,
  output logic      [W-1:0] SAVED
);
  typedef struct packed {
    logic [W-1:0] saved;
  } crms_shd_state_t;

  crms_shd_state_t state;
  crms_shd_state_t next_state;

  // no read or write path exists except this push capture
  always_comb begin
    next_state = state;
    if (PUSH) begin
      next_state.saved = HOST;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state <= '0;
    end else if (CLK_EN) begin
      state <= next_state;
    end
  end

  assign SAVED = state.saved;
endmodule

// ==== crms_core_regs.sv ====
// programmer-visible register model of the signal-controller core
//
// How it works
// - instruction fetch register holds 24-bit words from program memory.
// - 23-bit program counter, bit 0 zero, top bit masked normally.
// - sixteen 16-bit working registers usable as data, address, offset.
// - two 40-bit accumulators held alongside working registers.
// - last working register is stack pointer, adjusted on call, return, exception.
// - reset loads stack pointer with 0x0800.
// - byte operations change only the low byte of a working register.
// - data-space byte accesses reach either byte of any working register.
// - working register zero is the implicit file-register operand.
// - shadow push/pop moves registers zero to three and five status bits.
// - loop start pushes loop registers to shadows; loop end restores them.
// - shadows have no direct read or write path.
// - status word: low byte ALU flags, priority, repeat; high byte DSP, loop, carry.
// - exception entry stacks status low byte joined with program counter upper byte.
// - loop-active flag is read and clear only.
// - repeat-active flag read only, set by hardware on repeat entry.
// - DSP overflow flags are read only, set by overflow logic.
// - saturation flags sticky until software clears them.
// - clearing combined saturation also clears both individual ones.
// - data write to status word suppressed when the op updates status.
// - interrupt priorities 1 to 7; traps 8 to 15.
// - 8-bit page maps upper data half to program space, one extra cycle.
// - carry-input ops can only clear zero flag, never set it.
`timescale 1ns/1ps
module crms_core_regs import crms_pkg::*; (
  input  wire logic                CORE_CLK,
  input  wire logic                SYS_RST,
  input  wire logic                CLK_EN,
  input  wire logic                FETCH_VALID,
  input  wire logic [INSN_W-1:0]   FETCH_WORD,
  input  wire logic                PC_LOAD,
  input  wire logic [PC_W-1:0]     PC_VALUE,
  input  wire logic                PC_FULL_MODE,
  input  wire crms_wr_t            EXEC_WR,
  input  wire logic                DATA_WR,
  input  wire logic                DATA_BYTE,
  input  wire logic [4:0]          DATA_INDEX,
  input  wire logic                DATA_HIGH,
  input  wire logic [15:0]         DATA_WDATA,
  input  wire logic [4:0]          DATA_RINDEX,
  output logic      [15:0]         DATA_RDATA,
  input  wire logic                OP_SETS_FLAGS,
  input  wire logic                FLAG_UPDATE,
  input  wire crms_alu_flags_t     FLAGS_IN,
  input  wire logic                ACC_A_WR,
  input  wire logic                ACC_B_WR,
  input  wire logic [ACC_W-1:0]    ACC_WDATA,
  input  wire logic                OVF_A,
  input  wire logic                OVF_B,
  input  wire logic                SAT_A,
  input  wire logic                SAT_B,
  input  wire logic                STACK_PUSH,
  input  wire logic                STACK_POP,
  input  wire logic                EXCEPTION_ENTRY,
  input  wire logic [3:0]          EXCEPTION_PRIO,
  input  wire logic [2:0]          NEW_PRIO,
  input  wire logic                SHADOW_PUSH,
  input  wire logic                SHADOW_POP,
  input  wire logic                LOOP_START,
  input  wire logic                LOOP_END,
  input  wire crms_loop_t          LOOP_IN,
  input  wire logic                REPEAT_ENTRY,
  input  wire logic                REPEAT_DONE,
  input  wire logic                WINDOW_ACCESS,
  input  wire logic [14:0]         WINDOW_ADDR,
  output logic [INSN_W-1:0]        INSN_REG,
  output logic [PC_W-1:0]          PC_OUT,
  output logic [15:0]              SP_OUT,
  output logic [15:0]              WORK_OPERAND,
  output logic [ACC_W-1:0]         ACC_A_OUT,
  output logic [ACC_W-1:0]         ACC_B_OUT,
  output logic [15:0]              STATUS_OUT,
  output logic [15:0]              EXCEPTION_FRAME,
  output crms_loop_t               LOOP_OUT,
  output logic [PAGE_W-1:0]        PAGE_OUT,
  output logic [PC_W-1:0]          WINDOW_PROG_ADDR,
  output logic                     WINDOW_STALL,
  output logic                     PRIO_VALID
);
  // data-space register indices for memory-mapped access
  localparam logic [4:0] IDX_STATUS = 5'h10;
  localparam logic [4:0] IDX_PAGE   = 5'h11;

  typedef struct packed {
    logic [INSN_W-1:0]              insn;
    logic [PC_W-1:0]                pc;
    logic [WREG_COUNT-1:0][15:0]    w;
    logic [ACC_W-1:0]               acc_a;
    logic [ACC_W-1:0]               acc_b;
    logic [15:0]                    status;
    logic [PAGE_W-1:0]              page;
    crms_loop_t                     loops;
    logic                           window_wait;
  } crms_state_t;

  crms_state_t state;
  crms_state_t next_state;

  logic [3:0][15:0] shadow_w;
  logic [15:0]      shadow_status;
  crms_loop_t       shadow_loop;

  ////////////////////////////////////////////////////////////////////////////
  // shadow registers
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_wshadow
      crms_shadow #(.W(16)) u_shadow (
        .CORE_CLK (CORE_CLK),
        .SYS_RST  (SYS_RST),
        .CLK_EN   (CLK_EN),
        .PUSH     (SHADOW_PUSH),
        .HOST     (state.w[g]),
        .SAVED    (shadow_w[g])
      );
    end
  endgenerate

  crms_shadow #(.W(16)) u_status_shadow (
    .CORE_CLK (CORE_CLK),
    .SYS_RST  (SYS_RST),
    .CLK_EN   (CLK_EN),
    .PUSH     (SHADOW_PUSH),
    .HOST     (state.status & SHADOW_MASK),
    .SAVED    (shadow_status)
  );

  crms_shadow #(.W(48)) u_loop_shadow (
    .CORE_CLK (CORE_CLK),
    .SYS_RST  (SYS_RST),
    .CLK_EN   (CLK_EN),
    .PUSH     (LOOP_START),
    .HOST     (state.loops),
    .SAVED    (shadow_loop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic [15:0] wval;
    logic [15:0] sw_val;
    logic        zero_next;
    logic [7:0]  low_b;
    logic [7:0]  high_b;
    wval       = 16'h0000;
    sw_val     = 16'h0000;
    zero_next  = 1'b0;
    low_b      = 8'h00;
    high_b     = 8'h00;
    next_state = state;

    if (FETCH_VALID) begin
      next_state.insn = FETCH_WORD;
    end
    if (PC_LOAD) begin
      next_state.pc = PC_VALUE & {PC_FULL_MODE, {(PC_W-2){1'b1}}, 1'b0};
    end

    // execution write port; byte ops keep the high byte
    if (EXEC_WR.wr) begin
      wval = state.w[EXEC_WR.index];
      if (EXEC_WR.byte_op) begin
        wval[7:0] = EXEC_WR.data[7:0];
      end else begin
        wval = EXEC_WR.data;
      end
      next_state.w[EXEC_WR.index] = wval;
    end

    // memory-mapped data-space writes, either byte reachable
    if (DATA_WR && !DATA_INDEX[4]) begin
      wval = next_state.w[DATA_INDEX[3:0]];
      if (!DATA_BYTE) begin
        wval = DATA_WDATA;
      end else if (DATA_HIGH) begin
        wval[15:8] = DATA_WDATA[7:0];
      end else begin
        wval[7:0] = DATA_WDATA[7:0];
      end
      next_state.w[DATA_INDEX[3:0]] = wval;
    end

    // stack pointer moves on call, return and exception
    if (STACK_PUSH || EXCEPTION_ENTRY) begin
      next_state.w[SP_INDEX] = state.w[SP_INDEX] + 16'h0002;
    end else if (STACK_POP) begin
      next_state.w[SP_INDEX] = state.w[SP_INDEX] - 16'h0002;
    end
    next_state.w[SP_INDEX][0] = 1'b0;

    if (SHADOW_POP) begin
      for (int i = 0; i < 4; i++) begin
        next_state.w[i] = shadow_w[i];
      end
    end

    if (ACC_A_WR) begin
      next_state.acc_a = ACC_WDATA;
    end
    if (ACC_B_WR) begin
      next_state.acc_b = ACC_WDATA;
    end

    // software write of status: suppressed if the op also sets flags
    if (DATA_WR && DATA_INDEX == IDX_STATUS && !OP_SETS_FLAGS) begin
      low_b  = DATA_BYTE && DATA_HIGH ? state.status[7:0] : DATA_WDATA[7:0];
      high_b = DATA_BYTE ? (DATA_HIGH ? DATA_WDATA[7:0] : state.status[15:8]) : DATA_WDATA[15:8];
      sw_val = {high_b, low_b};
      // plain bits follow the write; clear-only bits may only fall
      next_state.status = (state.status & SW_RO_MASK)
                        | (sw_val & ~SW_RO_MASK & ~SW_CLR_MASK)
                        | (sw_val & state.status & SW_CLR_MASK);
      if (!sw_val[BIT_SAB]) begin
        next_state.status[BIT_SA] = 1'b0;
        next_state.status[BIT_SB] = 1'b0;
      end
    end
    if (DATA_WR && DATA_INDEX == IDX_PAGE) begin
      next_state.page = DATA_WDATA[PAGE_W-1:0];
    end

    if (FLAG_UPDATE) begin
      next_state.status[BIT_CARRY]  = FLAGS_IN.carry;
      next_state.status[BIT_OVF]    = FLAGS_IN.ovf;
      next_state.status[BIT_NEG]    = FLAGS_IN.neg;
      next_state.status[BIT_DCARRY] = FLAGS_IN.dcarry;
      // carry-chained ops only clear zero, so a multi-word zero test ANDs
      zero_next = FLAGS_IN.zero_chain ? (state.status[BIT_ZERO] & FLAGS_IN.zero) : FLAGS_IN.zero;
      next_state.status[BIT_ZERO] = zero_next;
    end
    if (SHADOW_POP) begin
      next_state.status = (next_state.status & ~SHADOW_MASK) | (shadow_status & SHADOW_MASK);
    end

    // overflow flags follow the overflow logic only
    next_state.status[BIT_OA]  = OVF_A;
    next_state.status[BIT_OB]  = OVF_B;
    next_state.status[BIT_OAB] = OVF_A | OVF_B;
    // saturation sticky: set beats a same-cycle clear
    if (SAT_A) begin
      next_state.status[BIT_SA]  = 1'b1;
      next_state.status[BIT_SAB] = 1'b1;
    end
    if (SAT_B) begin
      next_state.status[BIT_SB]  = 1'b1;
      next_state.status[BIT_SAB] = 1'b1;
    end

    if (REPEAT_ENTRY) begin
      next_state.status[BIT_RPT] = 1'b1;
    end else if (REPEAT_DONE) begin
      next_state.status[BIT_RPT] = 1'b0;
    end

    if (LOOP_START) begin
      next_state.loops              = LOOP_IN;
      next_state.status[BIT_LOOP]   = 1'b1;
    end else if (LOOP_END) begin
      next_state.loops = shadow_loop;
    end

    if (EXCEPTION_ENTRY && EXCEPTION_PRIO <= TRAP_PRIO_MAX && EXCEPTION_PRIO <= {1'b0, IRQ_PRIO_MAX}) begin
      next_state.status[BIT_PRIO_LO +: 3] = EXCEPTION_PRIO[2:0];
    end else if (EXCEPTION_ENTRY) begin
      // traps raise the level to the ceiling of the interrupt range
      next_state.status[BIT_PRIO_LO +: 3] = IRQ_PRIO_MAX;
    end else if (DATA_WR && DATA_INDEX == IDX_STATUS && !OP_SETS_FLAGS && NEW_PRIO != 3'h0) begin
      next_state.status[BIT_PRIO_LO +: 3] = next_state.status[BIT_PRIO_LO +: 3];
    end

    // program window costs one extra cycle
    next_state.window_wait = WINDOW_ACCESS && !state.window_wait;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state                  <= '0;
      state.w[SP_INDEX]      <= SP_RESET;
      state.status           <= STATUS_RESET;
      state.page             <= PAGE_RESET;
    end else if (CLK_EN) begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read paths: shadows deliberately absent from the map
  always_comb begin
    if (!DATA_RINDEX[4]) begin
      DATA_RDATA = state.w[DATA_RINDEX[3:0]];
    end else if (DATA_RINDEX == IDX_STATUS) begin
      DATA_RDATA = state.status;
    end else if (DATA_RINDEX == IDX_PAGE) begin
      DATA_RDATA = {8'h00, state.page};
    end else begin
      DATA_RDATA = 16'h0000;
    end
  end

  assign INSN_REG         = state.insn;
  assign PC_OUT           = state.pc;
  assign SP_OUT           = state.w[SP_INDEX];
  assign WORK_OPERAND     = state.w[DEFAULT_INDEX];
  assign ACC_A_OUT        = state.acc_a;
  assign ACC_B_OUT        = state.acc_b;
  assign STATUS_OUT       = state.status;
  assign EXCEPTION_FRAME  = {state.status[7:0], 1'b0, state.pc[PC_W-1:16]};
  assign LOOP_OUT         = state.loops;
  assign PAGE_OUT         = state.page;
  assign WINDOW_PROG_ADDR = {state.page, WINDOW_ADDR[14:1], 1'b0};
  assign WINDOW_STALL     = WINDOW_ACCESS && !state.window_wait;
  assign PRIO_VALID       = NEW_PRIO >= IRQ_PRIO_MIN;
endmodule

// ==== crms_core_regs_chk.sv ====
// assertion checker bound to the core register model ports
`timescale 1ns/1ps
module crms_core_regs_chk import crms_pkg::*; (
  input wire logic            CORE_CLK,
  input wire logic            SYS_RST,
  input wire logic            CLK_EN,
  input wire logic            STACK_PUSH,
  input wire logic            STACK_POP,
  input wire logic            EXCEPTION_ENTRY,
  input wire logic            DATA_WR,
  input wire logic            DATA_BYTE,
  input wire logic [4:0]      DATA_INDEX,
  input wire logic [15:0]     DATA_WDATA,
  input wire logic            OP_SETS_FLAGS,
  input wire logic            OVF_A,
  input wire logic            SAT_A,
  input wire logic            SAT_B,
  input wire logic            LOOP_START,
  input wire logic            REPEAT_ENTRY,
  input wire logic [2:0]      NEW_PRIO,
  input wire logic            WINDOW_ACCESS,
  input wire logic [15:0]     SP_OUT,
  input wire logic [PC_W-1:0] PC_OUT,
  input wire logic [15:0]     STATUS_OUT,
  input wire logic [15:0]     EXCEPTION_FRAME,
  input wire logic            PRIO_VALID,
  input wire logic            WINDOW_STALL
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  wire logic st_wr;
  assign st_wr = CLK_EN && DATA_WR && DATA_INDEX == 5'h10;
  ////////////////////////////////////////////////////////////////////////////////
  chk_sp_reset: assert property (disable iff (1'b0) SYS_RST |=> SP_OUT == SP_RESET)
    else $error("stack pointer not at reset value");
  chk_sp_push: assert property (CLK_EN && STACK_PUSH && !STACK_POP && !EXCEPTION_ENTRY |=> SP_OUT == $past(SP_OUT) + 16'h0002)
    else $error("stack pointer push step wrong");
  chk_loop_flag: assert property (!STATUS_OUT[BIT_LOOP] && !(CLK_EN && LOOP_START) |=> !STATUS_OUT[BIT_LOOP])
    else $error("loop flag set without loop start");
  chk_rpt_source: assert property ($rose(STATUS_OUT[BIT_RPT]) |-> $past(REPEAT_ENTRY))
    else $error("repeat flag set without repeat entry");
  chk_ovf_source: assert property ($rose(STATUS_OUT[BIT_OA]) |-> $past(OVF_A))
    else $error("overflow flag set without overflow");
  chk_sat_sticky: assert property (STATUS_OUT[BIT_SA] && !st_wr |=> STATUS_OUT[BIT_SA])
    else $error("saturation flag dropped");
  chk_sab_clear: assert property (st_wr && !DATA_BYTE && !DATA_WDATA[BIT_SAB] && !OP_SETS_FLAGS && !SAT_A && !SAT_B
    |=> !STATUS_OUT[BIT_SA] && !STATUS_OUT[BIT_SB])
    else $error("combined clear left a saturation flag");
  chk_frame_join: assert property (EXCEPTION_FRAME == {STATUS_OUT[7:0], 1'b0, PC_OUT[22:16]})
    else $error("exception frame word wrong");
  chk_prio_range: assert property (PRIO_VALID == (NEW_PRIO >= IRQ_PRIO_MIN))
    else $error("priority validity wrong");
  chk_window_stall: assert property (WINDOW_ACCESS && !$past(WINDOW_ACCESS) |-> WINDOW_STALL)
    else $error("window access without extra cycle");
  cover property (st_wr && OP_SETS_FLAGS);
  cover property (CLK_EN && STACK_PUSH);
  cover property ($rose(STATUS_OUT[BIT_SA]));
endmodule
////////////////////////////////////////////////////////////////////////////////
bind crms_core_regs crms_core_regs_chk crms_core_regs_chk_inst (.CORE_CLK, .SYS_RST, .CLK_EN, .STACK_PUSH,
  .STACK_POP, .EXCEPTION_ENTRY, .DATA_WR, .DATA_BYTE, .DATA_INDEX, .DATA_WDATA, .OP_SETS_FLAGS, .OVF_A, .SAT_A,
  .SAT_B, .LOOP_START, .REPEAT_ENTRY, .NEW_PRIO, .WINDOW_ACCESS, .SP_OUT, .PC_OUT, .STATUS_OUT,
  .EXCEPTION_FRAME, .PRIO_VALID, .WINDOW_STALL);

// ==== tb_top.sv ====
// self-checking bench for the core register model
`timescale 1ns/1ps
module tb_top import crms_pkg::*; ;
  logic CORE_CLK, SYS_RST, CLK_EN, FETCH_VALID, PC_LOAD, PC_FULL_MODE, DATA_WR, DATA_BYTE, DATA_HIGH;
  logic OP_SETS_FLAGS, FLAG_UPDATE, ACC_A_WR, ACC_B_WR, OVF_A, OVF_B, SAT_A, SAT_B, STACK_PUSH, STACK_POP;
  logic EXCEPTION_ENTRY, SHADOW_PUSH, SHADOW_POP, LOOP_START, LOOP_END, REPEAT_ENTRY, REPEAT_DONE;
  logic WINDOW_ACCESS, WINDOW_STALL, PRIO_VALID;
  logic [INSN_W-1:0] FETCH_WORD, INSN_REG;
  logic [PC_W-1:0]   PC_VALUE, PC_OUT, WINDOW_PROG_ADDR;
  logic [4:0]        DATA_INDEX, DATA_RINDEX;
  logic [15:0]       DATA_WDATA, DATA_RDATA, SP_OUT, WORK_OPERAND, STATUS_OUT, EXCEPTION_FRAME;
  logic [ACC_W-1:0]  ACC_WDATA, ACC_A_OUT, ACC_B_OUT;
  logic [3:0]        EXCEPTION_PRIO;
  logic [2:0]        NEW_PRIO;
  logic [14:0]       WINDOW_ADDR;
  logic [PAGE_W-1:0] PAGE_OUT;
  crms_wr_t          EXEC_WR;
  crms_alu_flags_t   FLAGS_IN;
  crms_loop_t        LOOP_IN, LOOP_OUT;
  int                err_total, check_count;
  crms_core_regs crms_core_regs_inst (.CORE_CLK, .SYS_RST, .CLK_EN, .FETCH_VALID, .FETCH_WORD, .PC_LOAD,
    .PC_VALUE, .PC_FULL_MODE, .EXEC_WR, .DATA_WR, .DATA_BYTE, .DATA_INDEX, .DATA_HIGH, .DATA_WDATA,
    .DATA_RINDEX, .DATA_RDATA, .OP_SETS_FLAGS, .FLAG_UPDATE, .FLAGS_IN, .ACC_A_WR, .ACC_B_WR, .ACC_WDATA,
    .OVF_A, .OVF_B, .SAT_A, .SAT_B, .STACK_PUSH, .STACK_POP, .EXCEPTION_ENTRY, .EXCEPTION_PRIO, .NEW_PRIO,
    .SHADOW_PUSH, .SHADOW_POP, .LOOP_START, .LOOP_END, .LOOP_IN, .REPEAT_ENTRY, .REPEAT_DONE,
    .WINDOW_ACCESS, .WINDOW_ADDR, .INSN_REG, .PC_OUT, .SP_OUT, .WORK_OPERAND, .ACC_A_OUT, .ACC_B_OUT,
    .STATUS_OUT, .EXCEPTION_FRAME, .LOOP_OUT, .PAGE_OUT, .WINDOW_PROG_ADDR, .WINDOW_STALL, .PRIO_VALID);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic step();
    @(posedge CORE_CLK);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step();
    s = 1'b0;
    // idle edge so a repeated strobe never rises in the step it fell
    step();
  endtask
  task automatic wr(input logic [4:0] idx, input logic [15:0] d, input logic bt = 1'b0, input logic hi = 1'b0);
    {DATA_INDEX, DATA_WDATA, DATA_BYTE, DATA_HIGH} = {idx, d, bt, hi};
    pulse(DATA_WR);
  endtask
  // combinational read port, looked at on the stimulus grid
  task automatic rchk(input logic [4:0] idx, input logic [15:0] exp);
    DATA_RINDEX = idx;
    step();
    chk("rdata", DATA_RDATA, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int i = 0; i < 16; i++) wr(5'(i), {4'(i), 12'hA53});
    for (int i = 0; i < 16; i++) rchk(5'(i), {4'(i), 12'hA52} | 16'(i != 15));
    chk("w0", WORK_OPERAND, 16'h0A53);
    rchk(5'h1F, 16'h0000);
  endtask
  task automatic t_stack();
    wr(5'h0F, 16'h1235);
    chk("sp", SP_OUT, 16'h1234);
    pulse(STACK_PUSH);
    chk("sp", SP_OUT, 16'h1236);
    pulse(STACK_POP);
    CLK_EN = 1'b0;
    pulse(STACK_PUSH);
    CLK_EN = 1'b1;
    chk("sp", SP_OUT, 16'h1234);
    {PC_VALUE, PC_FULL_MODE} = {23'h7FFFFF, 1'b0};
    pulse(PC_LOAD);
    chk("pc", PC_OUT, 23'h3FFFFE);
    PC_FULL_MODE = 1'b1;
    pulse(PC_LOAD);
    chk("pc", PC_OUT, 23'h7FFFFE);
    EXCEPTION_PRIO = 4'h9;
    pulse(EXCEPTION_ENTRY);
    chk("sp", SP_OUT, 16'h1236);
    chk("frame", EXCEPTION_FRAME, 16'hE07F);
    EXCEPTION_PRIO = 4'h3;
    pulse(EXCEPTION_ENTRY);
    chk("status", STATUS_OUT, 16'h0060);
    for (int p = 0; p < 8; p++) begin
      NEW_PRIO = 3'(p);
      step();
      chk("prio", PRIO_VALID, 48'(p >= 1));
    end
    FETCH_WORD = 24'hC3A5E1;
    pulse(FETCH_VALID);
    chk("insn", INSN_REG, 24'hC3A5E1);
    ACC_WDATA = 40'h9A12345678;
    pulse(ACC_A_WR);
    ACC_WDATA = 40'h0F00000001;
    pulse(ACC_B_WR);
    chk("acc", {ACC_A_OUT[19:0], ACC_B_OUT[39:20]}, 40'h45678_0F000);
  endtask
  task automatic t_shadow();
    FLAGS_IN = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    pulse(FLAG_UPDATE);
    pulse(SHADOW_PUSH);
    for (int i = 0; i < 4; i++) wr(5'(i), 16'h0000);
    FLAGS_IN = '0;
    pulse(FLAG_UPDATE);
    chk("status", STATUS_OUT, 16'h0060);
    pulse(SHADOW_POP);
    for (int i = 0; i < 4; i++) rchk(5'(i), {4'(i), 12'hA53});
    chk("status", STATUS_OUT, 16'h016F);
  endtask
  task automatic t_bytes();
    wr(5'h02, 16'hBEEF);
    EXEC_WR = '{1'b1, 1'b1, 1'b0, 4'h2, 16'h1234};
    step();
    EXEC_WR.wr = 1'b0;
    rchk(5'h02, 16'hBE34);
    wr(5'h02, 16'h0077, 1'b1, 1'b1);
    rchk(5'h02, 16'h7734);
    wr(5'h02, 16'h00C1, 1'b1, 1'b0);
    rchk(5'h02, 16'h77C1);
  endtask
  task automatic t_status();
    LOOP_IN = '{16'h0001, 16'h0002, 16'h0003};
    pulse(LOOP_START);
    LOOP_IN = '{16'h0004, 16'h0005, 16'h0006};
    pulse(LOOP_START);
    chk("loop", LOOP_OUT, 48'h0004_0005_0006);
    pulse(LOOP_END);
    chk("loop", LOOP_OUT, 48'h0001_0002_0003);
    wr(5'h10, 16'hFFFF);
    chk("status", STATUS_OUT, 16'h03EF);
    wr(5'h10, 16'h0000);
    wr(5'h10, 16'hFFFF);
    chk("status", STATUS_OUT, 16'h01EF);
    OP_SETS_FLAGS = 1'b1;
    wr(5'h10, 16'h0000);
    OP_SETS_FLAGS = 1'b0;
    chk("status", STATUS_OUT, 16'h01EF);
    wr(5'h10, 16'h0000);
    chk("status", STATUS_OUT, 16'h0004);
    pulse(FLAG_UPDATE);
    pulse(REPEAT_ENTRY);
    wr(5'h10, 16'h0000);
    chk("status", STATUS_OUT, 16'h0010);
    pulse(REPEAT_DONE);
    OVF_A = 1'b1;
    step();
    OVF_A = 1'b0;
    chk("status", STATUS_OUT, 16'h8800);
    OVF_B = 1'b1;
    step();
    OVF_B = 1'b0;
    chk("status", STATUS_OUT, 16'h4800);
    pulse(SAT_A);
    step();
    chk("status", STATUS_OUT, 16'h2400);
    wr(5'h10, 16'h2000);
    chk("status", STATUS_OUT, 16'h0000);
    pulse(SAT_B);
    wr(5'h10, 16'h0400);
    chk("status", STATUS_OUT, 16'h0400);
    // zero flag through a chained sequence: set, hold, clear, stay clear
    for (int k = 0; k < 4; k++) begin
      FLAGS_IN = '{1'b0, k != 2, k != 0, 1'b0, 1'b0, 1'b0};
      pulse(FLAG_UPDATE);
      chk("zero", STATUS_OUT[BIT_ZERO], 48'(k < 2));
    end
  endtask
  task automatic t_window();
    wr(5'h11, 16'h00A7);
    chk("page", PAGE_OUT, 8'hA7);
    {WINDOW_ADDR, WINDOW_ACCESS} = {15'h0124, 1'b1};
    #0.2;
    chk("stall", WINDOW_STALL, 1'b1);
    chk("paddr", WINDOW_PROG_ADDR, 48'h538124);
    step();
    chk("stall", WINDOW_STALL, 1'b0);
    WINDOW_ACCESS = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end
  initial begin
    #400000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    err_total = 0;
    check_count = 0;
    {SYS_RST, CLK_EN} = 2'b11;
    {FETCH_VALID, PC_LOAD, DATA_WR, FLAG_UPDATE, ACC_A_WR, ACC_B_WR, SAT_A, SAT_B, STACK_PUSH} = '0;
    {STACK_POP, EXCEPTION_ENTRY, SHADOW_PUSH, SHADOW_POP, LOOP_START, LOOP_END, REPEAT_ENTRY} = '0;
    {REPEAT_DONE, OVF_A, OVF_B, OP_SETS_FLAGS, WINDOW_ACCESS, WINDOW_ADDR, PC_FULL_MODE, PC_VALUE} = '0;
    {FETCH_WORD, DATA_BYTE, DATA_HIGH, DATA_INDEX, DATA_WDATA, DATA_RINDEX, ACC_WDATA} = '0;
    {EXCEPTION_PRIO, NEW_PRIO, EXEC_WR, FLAGS_IN, LOOP_IN} = '0;
    repeat (8) @(posedge CORE_CLK);
    #1;
    SYS_RST = 1'b0;
    chk("sp", SP_OUT, 16'h0800);
    chk("status", {STATUS_OUT, PAGE_OUT}, 24'h0);
    step();
    t_regs();
    t_stack();
    t_shadow();
    t_bytes();
    t_status();
    t_window();
    tally_and_finish();
  end
endmodule
